/* hdl/rpc_pin_config.sv */
/*
 * Reset-time pin configuration: samples the bus fault pin and the data
 * lines while reset is held, then latches the pin functions that the
 * chip uses out of reset.
 * Assumes the pins are asynchronous and held steady for at least three
 * clock edges before reset is released, and that outside mode-select
 * drivers let go of the data lines before the first bus cycle.
 */
`timescale 1ns/1ns
`default_nettype none
module rpc_pin_config
    import rpc_pkg::*;
(
    input  wire logic              REF_CLK,
    input  wire logic              RST_N,
    input  wire logic              BUS_FAULT_PIN,
    input  wire logic [DATA_W-1:0] DATA_PIN_I,
    output var  logic              DATA_PULLUP_EN,
    output var  logic [1:0]        BUS_MODE,
    output var  logic              ADDR_MID_BUS_EN,
    output var  logic              DATA_HI_BUS_EN,
    output var  logic              DATA_LO_BUS_EN,
    output var  logic              PORT_A_EN,
    output var  logic              PORT_B_EN,
    output var  logic              PORT_G_EN,
    output var  logic              PORT_H_EN,
    output var  logic              ADDR_LOW_HIZ,
    output var  logic              BUS_CTL_SEL,
    output var  logic [UPPER_W-1:0] UPPER_ADDR_SEL,
    output var  logic [UPPER_W-1:0] UPPER_CS_SEL,
    output var  logic              PORT_E_EN,
    output var  logic              PORT_F_EN,
    output var  logic              SLAVE_MODE,
    output var  logic              BOOT_CS_16BIT,
    output var  logic              BOOT_CS_ACTIVE,
    output var  logic              EMU_CS_EN,
    output var  logic              BUS_GRANT_TIED_HIGH,
    output var  logic              FIRST_BUS_CYCLE,
    output var  logic              BUS_CYCLE_EN
);

    // ----------------------------------------------------------------
    // pin synchronisation
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] data_s;
    logic              fault_s;

    rpc_sync #(
        .W (DATA_W)
    ) u_sync_data (
        .clk (REF_CLK),
        .d   (DATA_PIN_I),
        .q   (data_s)
    );

    rpc_sync #(
        .W (1)
    ) u_sync_fault (
        .clk (REF_CLK),
        .d   (BUS_FAULT_PIN),
        .q   (fault_s)
    );

    // ----------------------------------------------------------------
    // mode sample capture
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] samp_data_r;
    logic              samp_fault_r;
    logic              in_reset_r;
    logic              release_w;

    // no reset here: the sample has to follow the pins during reset
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            samp_data_r  <= data_s;
            samp_fault_r <= fault_s;
        end
    end

    // tells the release edge apart from every later one
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            in_reset_r <= 1'b1;
        end else begin
            in_reset_r <= 1'b0;
        end
    end

    // first edge with reset released; the only edge that loads config
    assign release_w = RST_N && in_reset_r;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    // pin n of the upper group is address if line n or any higher is low
    function automatic logic [UPPER_W-1:0] upper_addr_map(
        input logic [UPPER_W-1:0] lines
    );
        logic [UPPER_W-1:0] m;
        m = '0;
        for (int i = 0; i < UPPER_W; i++) begin
            for (int j = i; j < UPPER_W; j++) begin
                if (!lines[j]) begin
                    m[i] = 1'b1;
                end
            end
        end
        return m;
    endfunction

    rpc_bus_mode_e      mode_w;
    logic               is16_w;
    logic               expd_w;
    logic [1:0]         bus_mode_nxt;
    logic               addr_mid_nxt;
    logic               data_hi_nxt;
    logic               data_lo_nxt;
    logic               port_h_nxt;
    logic               port_abg_nxt;
    logic               bus_ctl_nxt;
    logic [UPPER_W-1:0] upper_addr_nxt;
    logic [UPPER_W-1:0] upper_cs_nxt;
    logic               port_e_nxt;
    logic               port_f_nxt;
    logic               slave_nxt;
    logic               boot16_nxt;
    logic               emu_nxt;
    logic               grant_tie_nxt;

    always_comb begin
        if (!samp_fault_r) begin
            mode_w = RPC_BUS_SINGLE;
        end else if (!samp_data_r[D_BUS_WIDTH]) begin
            mode_w = RPC_BUS_16;
        end else begin
            mode_w = RPC_BUS_8;
        end
    end

    assign is16_w = (mode_w == RPC_BUS_16);
    assign expd_w = (mode_w != RPC_BUS_SINGLE);

    // ----------------------------------------------------------------
    // per-option decode
    // ----------------------------------------------------------------
    always_comb begin
        bus_mode_nxt   = 2'(mode_w);
        addr_mid_nxt   = expd_w;
        data_hi_nxt    = expd_w;
        data_lo_nxt    = is16_w;
        port_h_nxt     = !is16_w;
        port_abg_nxt   = !expd_w;
        bus_ctl_nxt    = is16_w && !samp_data_r[D_BUS_CTL];
        upper_addr_nxt = '0;
        upper_cs_nxt   = '0;
        if (is16_w) begin
            upper_addr_nxt = upper_addr_map(samp_data_r[D_UPPER_HI:D_UPPER_LO]);
            upper_cs_nxt   = ~upper_addr_nxt;
        end else if (expd_w) begin
            upper_cs_nxt   = '1;
        end
        // single chip: both zero, the upper pins become discrete outputs
        port_e_nxt     = !expd_w || !samp_data_r[D_PORT_E];
        port_f_nxt     = !expd_w || !samp_data_r[D_PORT_F];
        slave_nxt      = !samp_data_r[D_SLAVE];
        boot16_nxt     = is16_w && samp_data_r[D_BOOT_SIZE];
        emu_nxt        = is16_w && !samp_data_r[D_EMU];
        grant_tie_nxt  = emu_nxt && !samp_data_r[D_GRANT_TIE];
    end

    // ----------------------------------------------------------------
    // latched pin functions
    // ----------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            DATA_PULLUP_EN <= PULLUP_RST;
        end else begin
            DATA_PULLUP_EN <= 1'b0;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            BUS_MODE <= BUS_MODE_RST;
        end else if (release_w) begin
            BUS_MODE <= bus_mode_nxt;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            ADDR_MID_BUS_EN <= FLAG_RST;
            DATA_HI_BUS_EN  <= FLAG_RST;
            DATA_LO_BUS_EN  <= FLAG_RST;
        end else if (release_w) begin
            ADDR_MID_BUS_EN <= addr_mid_nxt;
            DATA_HI_BUS_EN  <= data_hi_nxt;
            DATA_LO_BUS_EN  <= data_lo_nxt;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            PORT_A_EN <= FLAG_RST;
            PORT_B_EN <= FLAG_RST;
            PORT_G_EN <= FLAG_RST;
            PORT_H_EN <= FLAG_RST;
        end else if (release_w) begin
            PORT_A_EN <= port_abg_nxt;
            PORT_B_EN <= port_abg_nxt;
            PORT_G_EN <= port_abg_nxt;
            PORT_H_EN <= port_h_nxt;
        end
    end

    // low address pins float through reset until the mode is known
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            ADDR_LOW_HIZ <= HIZ_RST;
        end else if (release_w) begin
            ADDR_LOW_HIZ <= !expd_w;
        end
    end

    // ----------------------------------------------------------------
    // latched options
    // ----------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            BUS_CTL_SEL <= FLAG_RST;
        end else if (release_w) begin
            BUS_CTL_SEL <= bus_ctl_nxt;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            UPPER_ADDR_SEL <= UPPER_RST;
            UPPER_CS_SEL   <= UPPER_RST;
        end else if (release_w) begin
            UPPER_ADDR_SEL <= upper_addr_nxt;
            UPPER_CS_SEL   <= upper_cs_nxt;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            PORT_E_EN <= FLAG_RST;
            PORT_F_EN <= FLAG_RST;
        end else if (release_w) begin
            PORT_E_EN <= port_e_nxt;
            PORT_F_EN <= port_f_nxt;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            SLAVE_MODE <= FLAG_RST;
        end else if (release_w) begin
            SLAVE_MODE <= slave_nxt;
        end
    end

    // boot select must answer the very first fetch, so it rises on release
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            BOOT_CS_ACTIVE <= FLAG_RST;
        end else if (release_w) begin
            BOOT_CS_ACTIVE <= 1'b1;
        end
    end

    // 8-bit boot port is also what the other bus modes are left with
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            BOOT_CS_16BIT <= FLAG_RST;
        end else if (release_w) begin
            BOOT_CS_16BIT <= boot16_nxt;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            EMU_CS_EN <= FLAG_RST;
        end else if (release_w) begin
            EMU_CS_EN <= emu_nxt;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            BUS_GRANT_TIED_HIGH <= FLAG_RST;
        end else if (release_w) begin
            BUS_GRANT_TIED_HIGH <= grant_tie_nxt;
        end
    end

    // ----------------------------------------------------------------
    // first bus cycle timing
    // ----------------------------------------------------------------
    // nothing drives the data lines before this; outside drivers must be gone
    rpc_bus_timer u_timer (
        .clk         (REF_CLK),
        .rst_n       (RST_N),
        .first_cycle (FIRST_BUS_CYCLE),
        .bus_enable  (BUS_CYCLE_EN)
    );

endmodule
`default_nettype wire

/* hdl/rpc_pkg.sv */
/*
 * Shared constants for the reset pin configuration block: sample bit
 * positions on the data lines, bus mode codes, reset values and the
 * count of cycles before the first bus cycle.
 * Assumes one clock, a synchronous active low reset and the system
 * clock output running at the reference clock rate.
 */
// What this block does
// - bus fault high, data1 low: address [18:3] and data [15:0] form buses
// - bus fault high, data1 high: data [15:8] bus, data [7:0] port H
// - bus fault low: no buses; ports A, B, G and H take the pins
// - address [2:0] high impedance in single chip, driven in expanded modes
// - data lines weakly pulled high during reset; low selects alternate option
// - first bus cycle starts 10 clock output cycles after reset release
// - 16-bit mode: data2 low gives bus request and function codes
// - 16-bit mode: low data line n makes its pin and lower ones address
// - upper address pins act as chip selects or outputs per latched mode
// - data8 low turns bus control pins into port E
// - data9 low turns interrupt pins and clock mode pin into port F
// - data11 low enters slave test mode, high keeps normal operation
// - 16-bit mode: data0 low gives 8-bit boot port, high 16-bit
// - boot chip select active right at reset release
// - emulation chip select only when data10 and data1 both low
// - bus grant tied high when data13, data10 and data1 all low
package rpc_pkg;

    // ----------------------------------------------------------------
    // sample positions on the data lines
    // ----------------------------------------------------------------
    localparam int DATA_W         = 16;
    localparam int D_BOOT_SIZE    = 0;
    localparam int D_BUS_WIDTH    = 1;
    localparam int D_BUS_CTL      = 2;
    localparam int D_UPPER_LO     = 3;
    localparam int D_UPPER_HI     = 7;
    localparam int D_PORT_E       = 8;
    localparam int D_PORT_F       = 9;
    localparam int D_EMU          = 10;
    localparam int D_SLAVE        = 11;
    localparam int D_GRANT_TIE    = 13;
    localparam int UPPER_W        = D_UPPER_HI - D_UPPER_LO + 1;

    // ----------------------------------------------------------------
    // bus modes
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        RPC_BUS_16,
        RPC_BUS_8,
        RPC_BUS_SINGLE
    } rpc_bus_mode_e;

    // ----------------------------------------------------------------
    // reset values and timing
    // ----------------------------------------------------------------
    localparam logic [1:0]         BUS_MODE_RST   = 2'h0;
    localparam logic [UPPER_W-1:0] UPPER_RST      = 5'h00;
    localparam logic               FLAG_RST       = 1'b0;
    localparam logic               PULLUP_RST     = 1'b1;
    localparam logic               HIZ_RST        = 1'b1;
    localparam int                 FIRST_BUS_CYC  = 10;
    localparam int                 CNT_W          = 4;
    localparam logic [CNT_W-1:0]   CNT_RST        = 4'h0;
    localparam logic [CNT_W-1:0]   CNT_LAST       = CNT_W'(FIRST_BUS_CYC);

endpackage

/* hdl/rpc_sync.sv */
/*
 * Two flip-flop synchroniser for a group of pin inputs.
 * Assumes the inputs are asynchronous to the clock; no reset, so the
 * chain keeps sampling while the block is held in reset.
 */
`timescale 1ns/1ns
`default_nettype none
module rpc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    // first stage is read only by the second
    always_ff @(posedge clk) begin
        meta_r <= d;
        q      <= meta_r;
    end
endmodule
`default_nettype wire

/* hdl/rpc_bus_timer.sv */
/*
 * Counts clock output cycles after reset release and marks the first
 * bus cycle with a one-cycle pulse and a lasting enable.
 * Assumes the system clock output runs at the clock of this module.
 */
`timescale 1ns/1ns
`default_nettype none
module rpc_bus_timer
    import rpc_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    output var  logic first_cycle,
    output var  logic bus_enable
);
    logic [CNT_W-1:0] cnt_r;

    // saturates, so the pulse cannot repeat before the next reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_r <= CNT_RST;
        end else if (cnt_r != CNT_LAST) begin
            cnt_r <= cnt_r + CNT_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            first_cycle <= FLAG_RST;
        end else begin
            first_cycle <= (cnt_r == CNT_LAST - CNT_W'(1));
        end
    end

    // data lines are only ours to drive once this is up
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bus_enable <= FLAG_RST;
        end else if (cnt_r == CNT_LAST - CNT_W'(1)) begin
            bus_enable <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* verif/rpc_pin_config_checker.sv */
/*
 * Concurrent checks on the reset pin configuration outputs.
 * Assumes one clock and a synchronous active low reset; bound to the top.
 */
`timescale 1ns/1ns
`default_nettype none
module rpc_pin_chk
    import rpc_pkg::*;
(
    input wire logic               REF_CLK,
    input wire logic               RST_N,
    input wire logic               DATA_PULLUP_EN,
    input wire logic [1:0]         BUS_MODE,
    input wire logic               ADDR_MID_BUS_EN,
    input wire logic               DATA_HI_BUS_EN,
    input wire logic               DATA_LO_BUS_EN,
    input wire logic               PORT_A_EN,
    input wire logic               PORT_B_EN,
    input wire logic               PORT_G_EN,
    input wire logic               PORT_H_EN,
    input wire logic               ADDR_LOW_HIZ,
    input wire logic               BUS_CTL_SEL,
    input wire logic [UPPER_W-1:0] UPPER_ADDR_SEL,
    input wire logic [UPPER_W-1:0] UPPER_CS_SEL,
    input wire logic               PORT_E_EN,
    input wire logic               PORT_F_EN,
    input wire logic               BOOT_CS_16BIT,
    input wire logic               BOOT_CS_ACTIVE,
    input wire logic               EMU_CS_EN,
    input wire logic               BUS_GRANT_TIED_HIGH,
    input wire logic               FIRST_BUS_CYCLE,
    input wire logic               BUS_CYCLE_EN
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);

    // boot select high marks a loaded configuration
    property p_wide;
        BOOT_CS_ACTIVE && BUS_MODE == RPC_BUS_16 |-> ADDR_MID_BUS_EN && DATA_HI_BUS_EN
            && DATA_LO_BUS_EN && !PORT_H_EN && !PORT_A_EN;
    endproperty
    property p_narrow;
        BOOT_CS_ACTIVE && BUS_MODE == RPC_BUS_8 |-> DATA_HI_BUS_EN && !DATA_LO_BUS_EN
            && PORT_H_EN && UPPER_CS_SEL == 5'h1f && !EMU_CS_EN;
    endproperty
    property p_single;
        BOOT_CS_ACTIVE && BUS_MODE == RPC_BUS_SINGLE |-> PORT_A_EN && PORT_B_EN && PORT_G_EN
            && PORT_H_EN && !ADDR_MID_BUS_EN && !DATA_HI_BUS_EN && UPPER_CS_SEL == 5'h00
            && PORT_E_EN && PORT_F_EN;
    endproperty
    property p_hiz;
        ADDR_LOW_HIZ == (!BOOT_CS_ACTIVE || BUS_MODE == RPC_BUS_SINGLE);
    endproperty
    property p_pullup;
        $rose(RST_N) |-> DATA_PULLUP_EN ##1 !DATA_PULLUP_EN [*3];
    endproperty
    property p_first;
        $rose(RST_N) |-> !BUS_CYCLE_EN [*8] ##1 !BUS_CYCLE_EN [*2]
            ##1 (FIRST_BUS_CYCLE && BUS_CYCLE_EN) ##1 (!FIRST_BUS_CYCLE && BUS_CYCLE_EN);
    endproperty
    property p_therm;
        BOOT_CS_ACTIVE && BUS_MODE == RPC_BUS_16 |-> UPPER_CS_SEL == ~UPPER_ADDR_SEL
            && (UPPER_ADDR_SEL & (UPPER_ADDR_SEL + 5'h01)) == 5'h00;
    endproperty
    property p_boot;
        $rose(RST_N) |-> !BOOT_CS_ACTIVE ##1 BOOT_CS_ACTIVE;
    endproperty
    property p_only16;
        BUS_CTL_SEL || BOOT_CS_16BIT || EMU_CS_EN |-> BUS_MODE == RPC_BUS_16;
    endproperty
    property p_tie;
        BUS_GRANT_TIED_HIGH |-> EMU_CS_EN;
    endproperty
    property p_hold;
        BOOT_CS_ACTIVE |=> BOOT_CS_ACTIVE && $stable({BUS_MODE, UPPER_ADDR_SEL, UPPER_CS_SEL,
            PORT_E_EN, PORT_F_EN, BOOT_CS_16BIT, EMU_CS_EN, BUS_GRANT_TIED_HIGH, BUS_CTL_SEL});
    endproperty

    // ------------------------------------------------------------
    // assertions and covers
    // ------------------------------------------------------------
    a_wide:   assert property (p_wide) else $error("wide bus pins wrong");
    a_narrow: assert property (p_narrow) else $error("narrow bus pins wrong");
    a_single: assert property (p_single) else $error("single chip pins wrong");
    a_hiz:    assert property (p_hiz) else $error("low address drive wrong");
    a_pullup: assert property (p_pullup) else $error("pull-up timing wrong");
    a_first:  assert property (p_first) else $error("first bus cycle timing wrong");
    a_therm:  assert property (p_therm) else $error("upper pin split wrong");
    a_boot:   assert property (p_boot) else $error("boot select late");
    a_only16: assert property (p_only16) else $error("wide-only option in other mode");
    a_tie:    assert property (p_tie) else $error("grant tie without emulation");
    a_hold:   assert property (p_hold) else $error("configuration changed");

    c_wide:   cover property (BOOT_CS_ACTIVE && BUS_MODE == RPC_BUS_16 && BUS_GRANT_TIED_HIGH);
    c_narrow: cover property (BOOT_CS_ACTIVE && BUS_MODE == RPC_BUS_8 && PORT_E_EN);
    c_single: cover property (BOOT_CS_ACTIVE && BUS_MODE == RPC_BUS_SINGLE);
    c_first:  cover property (FIRST_BUS_CYCLE);
endmodule

bind rpc_pin_config rpc_pin_chk u_chk (.REF_CLK, .RST_N, .DATA_PULLUP_EN, .BUS_MODE,
    .ADDR_MID_BUS_EN, .DATA_HI_BUS_EN, .DATA_LO_BUS_EN, .PORT_A_EN, .PORT_B_EN, .PORT_G_EN,
    .PORT_H_EN, .ADDR_LOW_HIZ, .BUS_CTL_SEL, .UPPER_ADDR_SEL, .UPPER_CS_SEL, .PORT_E_EN,
    .PORT_F_EN, .BOOT_CS_16BIT, .BOOT_CS_ACTIVE, .EMU_CS_EN, .BUS_GRANT_TIED_HIGH,
    .FIRST_BUS_CYCLE, .BUS_CYCLE_EN);
`default_nettype wire

/* verif/rpc_mode_drv.sv */
/*
 * Outside mode-select driver and memory sharing the data lines.
 * Assumes the block's pull-up enable stands for the weak pull-ups.
 */
`timescale 1ns/1ns
`default_nettype none
module rpc_mode_drv
    import rpc_pkg::*;
#(
    parameter int HOLD_CYC = 3
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              pullup_en,
    input  wire logic [DATA_W-1:0] low_mask,
    output var  logic [DATA_W-1:0] data
);
    logic [3:0]        hold_r = 4'h0;
    logic [DATA_W-1:0] pat_r = 16'h5a3c;
    logic              driving;

    // released lines without pull-up show bus noise, never the last value
    always_ff @(posedge clk) begin
        pat_r <= {pat_r[14:0], ~pat_r[15]};
    end

    // lets go a few cycles after release, well before the first bus cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hold_r <= 4'h0;
        end else if (hold_r < 4'(HOLD_CYC)) begin
            hold_r <= hold_r + 4'h1;
        end
    end

    assign driving = !rst_n || (hold_r < 4'(HOLD_CYC));
    // active low drive beats the weak pull-up
    assign data = driving ? ((pullup_en ? '1 : pat_r) & ~low_mask)
                          : (pullup_en ? '1 : pat_r);
endmodule
`default_nettype wire

/* verif/rpc_pin_config_bench.sv */
/*
 * Self-checking bench: resets the block with each mode pattern held on
 * the pins and compares the latched pin functions and bus timing.
 * Assumes the partner driver model on the data lines.
 */
`timescale 1ns/1ns
`default_nettype none
module rpc_pin_config_bench
    import rpc_pkg::*;
;
    logic               REF_CLK = 1'b0;
    logic               RST_N = 1'b0;
    logic               BUS_FAULT_PIN = 1'b1;
    logic [DATA_W-1:0]  low_mask = 16'h0000;
    logic [DATA_W-1:0]  DATA_PIN_I;
    logic               DATA_PULLUP_EN, ADDR_MID_BUS_EN, DATA_HI_BUS_EN, DATA_LO_BUS_EN;
    logic               PORT_A_EN, PORT_B_EN, PORT_G_EN, PORT_H_EN, ADDR_LOW_HIZ, BUS_CTL_SEL;
    logic               PORT_E_EN, PORT_F_EN, SLAVE_MODE, BOOT_CS_16BIT, BOOT_CS_ACTIVE;
    logic               EMU_CS_EN, BUS_GRANT_TIED_HIGH, FIRST_BUS_CYCLE, BUS_CYCLE_EN;
    logic [1:0]         BUS_MODE;
    logic [UPPER_W-1:0] UPPER_ADDR_SEL, UPPER_CS_SEL;
    int                 n_mismatch = 0;
    int                 checks_done = 0;
    // fault pin in the top bit, lines held low below
    logic [16:0]        cfgs [8] = '{17'h10002, 17'h10000, 17'h12fff, 17'h10022,
                                     17'h12f04, 17'h00000, 17'h00800, 17'h10402};

    always #2 REF_CLK = ~REF_CLK;

    rpc_mode_drv u_drv (.clk(REF_CLK), .rst_n(RST_N), .pullup_en(DATA_PULLUP_EN),
        .low_mask(low_mask), .data(DATA_PIN_I));

    rpc_pin_config u_dut (.REF_CLK, .RST_N, .BUS_FAULT_PIN, .DATA_PIN_I, .DATA_PULLUP_EN,
        .BUS_MODE, .ADDR_MID_BUS_EN, .DATA_HI_BUS_EN, .DATA_LO_BUS_EN, .PORT_A_EN, .PORT_B_EN,
        .PORT_G_EN, .PORT_H_EN, .ADDR_LOW_HIZ, .BUS_CTL_SEL, .UPPER_ADDR_SEL, .UPPER_CS_SEL,
        .PORT_E_EN, .PORT_F_EN, .SLAVE_MODE, .BOOT_CS_16BIT, .BOOT_CS_ACTIVE, .EMU_CS_EN,
        .BUS_GRANT_TIED_HIGH, .FIRST_BUS_CYCLE, .BUS_CYCLE_EN);

    // ------------------------------------------------------------
    // compare and verdict
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic check_cfg(input logic f, input logic [15:0] m);
        logic [15:0] d;
        logic        w16, w8, sc;
        logic [4:0]  ua;
        d = ~m;
        sc = !f;
        w16 = f && !d[1];
        w8 = f && d[1];
        for (int i = 0; i < 5; i++) begin
            ua[i] = w16 && (|(m[7:3] >> i));
        end
        chk("bus_mode", 16'(BUS_MODE), sc ? 16'h2 : (w8 ? 16'h1 : 16'h0));
        chk("bus_pins", 16'({ADDR_MID_BUS_EN, DATA_HI_BUS_EN, DATA_LO_BUS_EN, PORT_A_EN,
            PORT_B_EN, PORT_G_EN, PORT_H_EN}), 16'({!sc, !sc, w16, sc, sc, sc, !w16}));
        chk("addr_low_hiz", 16'(ADDR_LOW_HIZ), 16'(sc));
        chk("bus_ctl", 16'(BUS_CTL_SEL), 16'(w16 && !d[2]));
        chk("upper_sel", 16'({UPPER_ADDR_SEL, UPPER_CS_SEL}),
            16'({ua, w16 ? ~ua : (w8 ? 5'h1f : 5'h00)}));
        chk("port_e_f", 16'({PORT_E_EN, PORT_F_EN}),
            16'({sc || !d[8], sc || !d[9]}));
        chk("slave", 16'(SLAVE_MODE), 16'(!d[11]));
        chk("boot16", 16'(BOOT_CS_16BIT), 16'(w16 && d[0]));
        chk("boot_pull", 16'({BOOT_CS_ACTIVE, DATA_PULLUP_EN}), 16'h2);
        chk("emu", 16'({EMU_CS_EN, BUS_GRANT_TIED_HIGH}),
            16'({w16 && !d[10], w16 && !d[10] && !d[13]}));
    endtask

    // reset with the pattern held, then follow the release
    task automatic run_cfg(input logic f, input logic [15:0] m);
        int n;
        @(posedge REF_CLK);
        RST_N <= 1'b0;
        BUS_FAULT_PIN <= f;
        low_mask <= m;
        repeat (4) @(posedge REF_CLK);
        #1;
        chk("reset_out", 16'({DATA_PULLUP_EN, ADDR_LOW_HIZ, BOOT_CS_ACTIVE, BUS_CYCLE_EN,
            BUS_MODE}), 16'h30);
        @(posedge REF_CLK);
        RST_N <= 1'b1;
        for (n = 1; n <= 12; n++) begin
            @(posedge REF_CLK);
            // pins turned round after release must be ignored
            if (n == 2) begin
                BUS_FAULT_PIN <= !f;
                low_mask <= ~m;
            end
            #1;
            if (n == 2) check_cfg(f, m);
            if (n >= 9 && n <= 11) chk("first_cyc", 16'({FIRST_BUS_CYCLE, BUS_CYCLE_EN}),
                n == 9 ? 16'h0 : (n == 10 ? 16'h3 : 16'h1));
        end
        check_cfg(f, m);
    endtask

    initial begin
        for (int k = 0; k < 8; k++) begin
            run_cfg(cfgs[k][16], cfgs[k][15:0]);
        end
        tally_and_finish();
    end

    initial begin
        #8000;
        n_mismatch++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
